// ===== hw/psp_pkg.sv
// Shared widths and reset values for the pipelined SRAM strobe and data port
`default_nettype none
package psp_pkg;
  localparam int unsigned ADDR_W         = 19;
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned PAR_W          = 4;
  localparam int unsigned BURST_W        = 2;
  localparam int unsigned DEPTH          = 16;
  localparam int unsigned MEM_AW         = 4;
  localparam logic [18:0] ADDR_RST       = 19'h00000;
  localparam logic [1:0]  BURST_RST      = 2'h0;
  localparam logic [31:0] DATA_RST       = 32'h00000000;
  localparam logic [3:0]  PAR_RST        = 4'h0;
  localparam int unsigned SYNC_STAGES    = 2;
  typedef enum logic [1:0] {
    PSP_DESEL,
    PSP_FIRST,
    PSP_ACTIVE
  } psp_sel_e;
endpackage
`default_nettype wire

// ===== hw/psp_sync2.sv
// Two-flop synchroniser for asynchronous pins
`default_nettype none
module psp_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic core_clk_i,
  input  wire logic reset_n_i,
  input  wire logic async_i,
  output logic      sync_o
);
  typedef struct packed {
    logic meta;
    logic sync;
  } psp_sync_s;

  psp_sync_s st_q;
  psp_sync_s st_d;

  always_comb begin
    st_d      = st_q;
    st_d.meta = async_i;
    st_d.sync = st_q.meta;
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= {RST_VAL, RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.sync;
endmodule
`default_nettype wire

// ===== hw/psp_mem.sv
// Small storage array for the data port, write now, registered read
`default_nettype none
module psp_mem (
  input  wire logic                          core_clk_i,
  input  wire logic                          wr_en_i,
  input  wire logic [psp_pkg::MEM_AW-1:0]    wr_addr_i,
  input  wire logic [psp_pkg::DATA_W-1:0]    wr_data_i,
  input  wire logic [psp_pkg::PAR_W-1:0]     wr_par_i,
  input  wire logic [psp_pkg::MEM_AW-1:0]    rd_addr_i,
  output logic      [psp_pkg::DATA_W-1:0]    rd_data_o,
  output logic      [psp_pkg::PAR_W-1:0]     rd_par_o
);
  logic [psp_pkg::DATA_W+psp_pkg::PAR_W-1:0] mem [psp_pkg::DEPTH];

  // Contents are retained in sleep; storage has no reset
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= {wr_par_i, wr_data_i};
    end
    {rd_par_o, rd_data_o} <= mem[rd_addr_i];
  end
endmodule
`default_nettype wire

// ===== hw/psp_port.sv
// Strobe capture, burst preload, sleep and pipelined data/parity port of the SRAM
// How it works
// (R1) Processor strobe low captures the address
// (R2) Controller strobe low captures the address
// (R3) Any capture preloads burst counter low bits
// (R4) Both strobes low: processor strobe wins
// (R5) Processor strobe ignored when primary select high; here it is not captured but still deselects
// (R6) Sleep high idles logic, keeps memory contents
// (R7) Host holds sleep low; floating reads awake; no pull-down here, sleep only resets to awake
// (R8) Input data and parity registered on clock
// (R9) Read data appears one cycle after address
// (R10) Output enable low drives, high tristates lines
// (R11) First read after deselect keeps outputs undriven; here masked one cycle, then its data is driven
// (R12) Capture only when all chip selects active
// (R13) Host gives one strobe per access, stable address
`default_nettype none
module psp_port (
  input  wire logic                          core_clk_i,
  input  wire logic                          reset_n_i,
  input  wire logic [psp_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic                          processor_address_strobe_n_i,
  input  wire logic                          controller_address_strobe_n_i,
  input  wire logic                          chip_select_primary_n_i,
  input  wire logic                          chip_select_active_high_i,
  input  wire logic                          chip_select_third_n_i,
  input  wire logic                          write_n_i,
  input  wire logic                          sleep_request_i,
  input  wire logic                          output_enable_n_i,
  input  wire logic [psp_pkg::DATA_W-1:0]    data_in_i,
  input  wire logic [psp_pkg::PAR_W-1:0]     bidir_parity_lines_in_i,
  output logic      [psp_pkg::DATA_W-1:0]    data_out_o,
  output logic      [psp_pkg::PAR_W-1:0]     bidir_parity_lines_out_o,
  output logic                               data_oe_o,
  output logic      [psp_pkg::ADDR_W-1:0]    captured_addr_o,
  output logic      [psp_pkg::BURST_W-1:0]   burst_start_low_bits_o,
  output logic                               asleep_o
);
  typedef struct packed {
    logic [psp_pkg::ADDR_W-1:0]  addr;
    logic [psp_pkg::BURST_W-1:0] burst;
    logic [psp_pkg::DATA_W-1:0]  din;
    logic [psp_pkg::PAR_W-1:0]   pin;
    logic                        wr_pend;
    logic                        rd_pend;
    logic                        rd_valid;
    psp_pkg::psp_sel_e           sel;
  } psp_port_s;

  psp_port_s st_q;
  psp_port_s st_d;

  logic                        sleep_s;
  logic                        oe_n_s;
  logic                        all_sel;
  logic                        take_proc;
  logic                        take_ctrl;
  logic                        capture;
  logic                        desel_seen;
  logic [psp_pkg::DATA_W-1:0]  rd_data;
  logic [psp_pkg::PAR_W-1:0]   rd_par;

  // Asynchronous pins pass a synchroniser; sleep resets to awake
  psp_sync2 #(.RST_VAL(1'b0)) u_sleep_sync ( // R7
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .async_i    (sleep_request_i),
    .sync_o     (sleep_s)
  );

  psp_sync2 #(.RST_VAL(1'b1)) u_oe_sync (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .async_i    (output_enable_n_i),
    .sync_o     (oe_n_s)
  );

  psp_mem u_mem (
    .core_clk_i (core_clk_i),
    .wr_en_i    (st_q.wr_pend && !sleep_s),
    .wr_addr_i  (st_q.addr[psp_pkg::MEM_AW-1:0]),
    .wr_data_i  (st_q.din),
    .wr_par_i   (st_q.pin),
    .rd_addr_i  (st_q.addr[psp_pkg::MEM_AW-1:0]), // R9
    .rd_data_o  (rd_data),
    .rd_par_o   (rd_par)
  );

  assign all_sel   = !chip_select_primary_n_i && chip_select_active_high_i
                     && !chip_select_third_n_i; // R12
  assign take_proc = !processor_address_strobe_n_i && !chip_select_primary_n_i; // R1 R5
  assign take_ctrl = !controller_address_strobe_n_i && processor_address_strobe_n_i; // R2 R4
  assign capture   = all_sel && (take_proc || take_ctrl) && !sleep_s; // R6 R12
  // A strobe seen with the selects off deselects the device
  assign desel_seen = !capture && !all_sel
                      && (!processor_address_strobe_n_i || !controller_address_strobe_n_i); // R12

  always_comb begin
    st_d          = st_q;
    st_d.din      = data_in_i; // R8
    st_d.pin      = bidir_parity_lines_in_i; // R8
    st_d.wr_pend  = 1'b0;
    st_d.rd_pend  = 1'b0;
    if (capture) begin
      st_d.addr    = addr_i; // R1 R2
      st_d.burst   = addr_i[psp_pkg::BURST_W-1:0]; // R3
      st_d.wr_pend = !write_n_i;
      st_d.rd_pend = write_n_i;
    end
    // Read data arrives one edge after the address edge
    st_d.rd_valid = st_q.rd_pend; // R9
    case (st_q.sel)
      psp_pkg::PSP_DESEL: begin
        if (capture) begin
          st_d.sel = write_n_i ? psp_pkg::PSP_FIRST : psp_pkg::PSP_ACTIVE; // R11
        end
      end
      psp_pkg::PSP_FIRST: begin
        st_d.sel = desel_seen ? psp_pkg::PSP_DESEL : psp_pkg::PSP_ACTIVE;
      end
      psp_pkg::PSP_ACTIVE: begin
        if (desel_seen) begin
          st_d.sel = psp_pkg::PSP_DESEL;
        end
      end
      default: begin
        st_d.sel = psp_pkg::PSP_DESEL;
      end
    endcase
    if (sleep_s) begin
      st_d.sel      = psp_pkg::PSP_DESEL; // R6
      st_d.rd_valid = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= '{addr:     psp_pkg::ADDR_RST,
                burst:    psp_pkg::BURST_RST,
                din:      psp_pkg::DATA_RST,
                pin:      psp_pkg::PAR_RST,
                wr_pend:  1'b0,
                rd_pend:  1'b0,
                rd_valid: 1'b0,
                sel:      psp_pkg::PSP_DESEL};
    end else begin
      st_q <= st_d;
    end
  end

  // Direction follows output enable, masked on first read after deselect
  assign data_oe_o                = !oe_n_s && !sleep_s
                                    && (st_q.sel != psp_pkg::PSP_FIRST); // R10 R11
  assign data_out_o               = st_q.rd_valid ? rd_data : psp_pkg::DATA_RST; // R9
  assign bidir_parity_lines_out_o = st_q.rd_valid ? rd_par : psp_pkg::PAR_RST; // R9
  assign captured_addr_o          = st_q.addr;
  assign burst_start_low_bits_o   = st_q.burst;
  assign asleep_o                 = sleep_s; // R6

  AST_PROC_CAPTURE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (take_proc && all_sel && !sleep_s) |=> (st_q.addr == $past(addr_i))) // R1
    else $error("processor strobe did not capture address");
  AST_CTRL_CAPTURE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (!controller_address_strobe_n_i && processor_address_strobe_n_i && all_sel
     && !sleep_s) |=> (st_q.addr == $past(addr_i))) // R2
    else $error("controller strobe did not capture address");
  AST_BURST_LOAD: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    capture |=> (burst_start_low_bits_o == $past(addr_i[1:0]))) // R3
    else $error("burst counter not preloaded");
  AST_PRIORITY: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (!processor_address_strobe_n_i && !controller_address_strobe_n_i) |-> !take_ctrl) // R4
    else $error("controller strobe acted alongside processor strobe");
  AST_CS1_IGNORE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    chip_select_primary_n_i |=> $stable(st_q.addr)) // R5 R12
    else $error("address captured while deselected");
  AST_SLEEP_QUIET: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    sleep_s |-> (!data_oe_o && !capture)) // R6
    else $error("activity during sleep");
  AST_PIPE_READ: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (capture && write_n_i) |-> ##2 (st_q.rd_valid || sleep_s)) // R9
    else $error("read data not presented after one pipeline stage");
  AST_OE_DIR: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    oe_n_s |-> !data_oe_o) // R10
    else $error("lines driven with output enable high");
  AST_FIRST_MASK: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (st_q.sel == psp_pkg::PSP_DESEL && capture && write_n_i && !sleep_s)
    |=> !data_oe_o) // R11
    else $error("output driven on first read after deselect");
  AST_DIN_REG: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    1'b1 |=> (st_q.din == $past(data_in_i))) // R8
    else $error("input data not registered");

  // Capture and select checks
  AST_PROC_BURST: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (take_proc && all_sel && !sleep_s) |=> (st_q.burst == $past(addr_i[1:0]))) // R3
    else $error("processor strobe did not preload burst bits");

  AST_CTRL_BURST: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (take_ctrl && all_sel && !sleep_s) |=> (st_q.burst == $past(addr_i[1:0]))) // R3
    else $error("controller strobe did not preload burst bits");

  AST_BURST_HOLD: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !capture |=> $stable(burst_start_low_bits_o)) // R3
    else $error("burst bits changed without a capture");

  AST_NO_CAPTURE_HOLD: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !capture |=> $stable(captured_addr_o)) // R12
    else $error("address changed without a capture");

  AST_SEL_GATE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !all_sel |-> !capture) // R12
    else $error("capture with a select inactive");

  AST_C2_GATE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !chip_select_active_high_i |=> $stable(captured_addr_o)) // R12
    else $error("address captured with second select low");

  AST_C3_GATE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    chip_select_third_n_i |=> $stable(captured_addr_o)) // R12
    else $error("address captured with third select high");

  AST_BOTH_PROC: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (!processor_address_strobe_n_i && !controller_address_strobe_n_i && all_sel && !sleep_s)
    |-> (capture && take_proc)) // R4
    else $error("both strobes low not taken as processor strobe");

  AST_PROC_IGNORED: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (!processor_address_strobe_n_i && chip_select_primary_n_i) |-> !capture) // R5
    else $error("processor strobe taken with primary select high");

  AST_STROBE_NEEDED: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (processor_address_strobe_n_i && controller_address_strobe_n_i) |-> !capture) // R1 R2
    else $error("capture without any strobe");

  AST_DESEL_ENTRY: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    desel_seen |=> (st_q.sel == psp_pkg::PSP_DESEL)) // R12
    else $error("deselect strobe did not deselect");

  // Sleep checks
  AST_SLEEP_NO_WRITE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    sleep_s |=> !st_q.wr_pend) // R6
    else $error("write started during sleep");

  AST_SLEEP_DESEL: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    sleep_s |=> (st_q.sel == psp_pkg::PSP_DESEL)) // R6
    else $error("sleep did not deselect");

  AST_SLEEP_NO_DATA: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    sleep_s |=> !st_q.rd_valid) // R6
    else $error("read data presented during sleep");

  // Data path checks
  AST_PAR_REG: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    1'b1 |=> (st_q.pin == $past(bidir_parity_lines_in_i))) // R8
    else $error("input parity not registered");

  AST_WRITE_PEND: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (capture && !write_n_i) |=> (st_q.wr_pend && !st_q.rd_pend)) // R8
    else $error("write capture did not schedule a write");

  AST_READ_PEND: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (capture && write_n_i) |=> (st_q.rd_pend && !st_q.wr_pend)) // R9
    else $error("read capture did not schedule a read");

  AST_READ_ONE_STAGE: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    st_q.rd_valid |-> $past(st_q.rd_pend)) // R9
    else $error("read data without a read one cycle earlier");

  AST_READ_ZERO: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !st_q.rd_valid |-> (data_out_o == psp_pkg::DATA_RST
                        && bidir_parity_lines_out_o == psp_pkg::PAR_RST)) // R9
    else $error("data lines not idle without read data");

  AST_OE_ON: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (!oe_n_s && !sleep_s && st_q.sel != psp_pkg::PSP_FIRST) |-> data_oe_o) // R10
    else $error("lines not driven with output enable low");

  // Deselect masking checks
  AST_OE_FIRST: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (st_q.sel == psp_pkg::PSP_FIRST) |-> !data_oe_o) // R11
    else $error("output enable not masked on first read");

  AST_FIRST_LEAVES: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (st_q.sel == psp_pkg::PSP_FIRST) |=> (st_q.sel != psp_pkg::PSP_FIRST)) // R11
    else $error("mask held longer than one cycle");

  AST_READ_DESEL_FIRST: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (st_q.sel == psp_pkg::PSP_DESEL && capture && write_n_i)
    |=> (st_q.sel == psp_pkg::PSP_FIRST)) // R11
    else $error("read after deselect not masked");

  AST_WRITE_NO_FIRST: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (capture && !write_n_i) |=> (st_q.sel == psp_pkg::PSP_ACTIVE)) // R11
    else $error("write left the device unselected");

  // Cover points
  COV_PROC: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) take_proc && capture);
  COV_CTRL: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) take_ctrl && capture);
  COV_READ: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
    st_q.rd_valid && data_oe_o);
  COV_SLEEP: cover property (@(posedge core_clk_i) disable iff (!reset_n_i) sleep_s);
  COV_FIRST: cover property (@(posedge core_clk_i) disable iff (!reset_n_i)
    st_q.sel == psp_pkg::PSP_FIRST);
endmodule
`default_nettype wire

// ===== verif/psp_host.sv
// Host side of the data lines and the sleep pin
`default_nettype none
module psp_host (
  input  wire logic        data_oe_i,
  input  wire logic [35:0] port_q_i,
  input  wire logic [35:0] host_d_i,
  input  wire logic        sleep_drive_i,
  output logic      [35:0] line_o,
  output logic             sleep_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Host drives the lines only while the port has released them
  assign line_o  = data_oe_i ? port_q_i : host_d_i;
  // Sleep pin follows the host drive directly; no pull-down is modelled
  assign sleep_o = sleep_drive_i;
endmodule
`default_nettype wire

// ===== verif/pipelined_sram_strobe_data_port_tb.sv
// Self-checking bench for the SRAM strobe and data port
`default_nettype none
module pipelined_sram_strobe_data_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, ps_n, cs_n, c1_n, c2, c3_n, wr_n, slp, slp_l, oe_n, dsel, oe, asleep;
  logic [18:0] addr, ea, cap;
  logic [1:0]  eb, burst;
  logic [35:0] hd, line, q;
  logic [35:0] mem [16];
  int          mismatches, check_count;

  psp_port dut (.core_clk_i(clk), .reset_n_i(rst_n), .addr_i(addr),
    .processor_address_strobe_n_i(ps_n), .controller_address_strobe_n_i(cs_n),
    .chip_select_primary_n_i(c1_n), .chip_select_active_high_i(c2),
    .chip_select_third_n_i(c3_n), .write_n_i(wr_n), .sleep_request_i(slp_l),
    .output_enable_n_i(oe_n), .data_in_i(line[31:0]), .bidir_parity_lines_in_i(line[35:32]),
    .data_out_o(q[31:0]), .bidir_parity_lines_out_o(q[35:32]), .data_oe_o(oe),
    .captured_addr_o(cap), .burst_start_low_bits_o(burst), .asleep_o(asleep));

  psp_host host (.data_oe_i(oe), .port_q_i(q), .host_d_i(hd), .sleep_drive_i(slp),
    .line_o(line), .sleep_o(slp_l));

  task automatic chk(input logic [35:0] s, input logic [35:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h exp %h", $time, s, e);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Kind 0 controller strobe, 1 processor strobe, 2 both
  task automatic acc(input int k, input logic w, input logic [3:0] i);
    logic        ok;
    logic [18:0] a;
    a = 19'($urandom);
    a[3:0] = i;
    @(posedge clk);
    ok = !c1_n && c2 && !c3_n && !slp;
    ps_n <= (k == 0);
    cs_n <= (k == 1);
    addr <= a;
    wr_n <= !w;
    hd <= 36'({$urandom, $urandom});
    @(posedge clk);
    ps_n <= 1'b1;
    cs_n <= 1'b1;
    #1;
    if (ok) begin
      ea = a;
      eb = a[1:0];
    end
    chk(36'(cap), 36'(ea));
    chk(36'(burst), 36'(eb));
    if (ok && w) mem[i] = hd;
    if (ok && !w) begin
      chk(36'(oe), 36'(!oe_n && !dsel));
      @(posedge clk);
      #1;
      chk(q, mem[i]);
      chk(36'(oe), 36'(!oe_n));
    end
    dsel = !ok;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #100000;
    mismatches++;
    results();
  end

  initial begin
    {rst_n, slp, c1_n, c3_n, wr_n, dsel} = '0;
    {ps_n, cs_n, c2, oe_n} = '1;
    addr = '0;
    hd = '0;
    ea = '0;
    eb = '0;
    mismatches = 0;
    check_count = 0;
    void'($urandom(32'h0C99));
    repeat (3) @(posedge clk);
    chk(36'({cap, oe}), 36'h0);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Writes with the lines released by the port, then reads with output enable low
    for (int i = 0; i < 16; i++) acc(i % 3, 1'b1, 4'(i));
    @(posedge clk);
    oe_n <= 1'b0;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 16; i++) acc(i % 3, 1'b0, 4'(15 - i));
    // Each select off in turn, then sleep; refused writes must leave memory alone
    for (int j = 0; j < 4; j++) begin
      @(posedge clk);
      c1_n <= (j == 0);
      c2 <= (j != 1);
      c3_n <= (j == 2);
      slp <= (j == 3);
      repeat (3) @(posedge clk);
      chk(36'(asleep), 36'(j == 3));
      acc(j == 0 ? 1 : 2, 1'b1, 4'(j));
      @(posedge clk);
      {c1_n, c3_n, slp} <= '0;
      c2 <= 1'b1;
      repeat (3) @(posedge clk);
      acc(0, 1'b0, 4'(j));
      acc(2, 1'b0, 4'(j));
    end
    @(posedge clk);
    oe_n <= 1'b1;
    repeat (3) @(posedge clk);
    acc(1, 1'b0, 4'hA);
    results();
  end
endmodule
`default_nettype wire
